// ---- logic/mmu_defines.vh ----
// constants for the translation unit register file and buffer
//
// Functional notes
// - five control registers decoded by plain address
// - register access only in privileged mode
// - entry-high holds page number and process id
// - faults load faulting page number into entry-high
// - fault capture writes upper 22 address bits
// - load instruction copies entry registers into buffer
// - entry-low changes only by software writes
// - table base is plain software storage
// - fault address register captures full faulting address
// - fault address held until next exception or software write
// - 128 entries, four ways of 32
// - 4-kbyte page: bits 31-12 page, 11-0 offset
// - set index from page bits, optionally xor process id
// - hit needs valid, page and process id match; size bit skips bits 11-10, sharing bit skips process id
// - single-virtual privileged access skips process id compare
// - dirty and protection key checks raise exceptions
`ifndef MMU_DEFINES_VH
`define MMU_DEFINES_VH
// ****************************************
// register addresses
// ****************************************
`define MMU_ADDR_CTRL     32'h0fffffe0
`define MMU_ADDR_HIGH     32'h0ffffff0
`define MMU_ADDR_LOW      32'h0ffffff4
`define MMU_ADDR_TBASE    32'h0ffffff8
`define MMU_ADDR_FAULT    32'h0ffffffc
// ****************************************
// translation control fields and reset
// ****************************************
`define MMU_CTRL_AT       0
`define MMU_CTRL_TF       2
`define MMU_CTRL_SINGLE   8
`define MMU_CTRL_XIDX     9
`define MMU_CTRL_RST      32'h00000000
`define MMU_CTRL_MASK     32'h00000301
// ****************************************
// entry-high and entry-low fields
// ****************************************
`define MMU_HI_PAGE_MSB   31
`define MMU_HI_PAGE_LSB   10
`define MMU_HI_PROC_MSB   7
`define MMU_LO_FRAME_MSB  28
`define MMU_LO_FRAME_LSB  10
`define MMU_LO_V          8
`define MMU_LO_KEY_MSB    6
`define MMU_LO_KEY_LSB    5
`define MMU_LO_SIZE       4
`define MMU_LO_C          3
`define MMU_LO_D          2
`define MMU_LO_SHARE      1
`endif

// ---- logic/mmu_regs_tlb.v ----
// translation unit: control registers and 4-way translation buffer
`include "mmu_defines.vh"
module mmu_regs_tlb #(
    parameter WAYS = 4,
    parameter SETS = 32
) (
    // clock and reset
    input  wire        CORE_CLK_IN,
    input  wire        RSTN_IN,
    // core state
    input  wire        PRIV_IN,
    // register access
    input  wire        REG_WR_IN,
    input  wire        REG_RD_IN,
    input  wire [31:0] REG_ADDR_IN,
    input  wire [31:0] REG_WDATA_IN,
    output reg  [31:0] REG_RDATA_OUT,
    output reg         REG_ACK_OUT,
    output reg         REG_ERR_OUT,
    // entry load and fault capture
    input  wire        LOAD_ENTRY_IN,
    input  wire        FAULT_IN,
    input  wire [31:0] FAULT_VADDR_IN,
    // translation lookup
    input  wire        LOOKUP_IN,
    input  wire        LOOKUP_WRITE_IN,
    input  wire [31:0] LOOKUP_VADDR_IN,
    output reg         DONE_OUT,
    output reg         HIT_OUT,
    output reg         MISS_OUT,
    output reg  [31:0] PADDR_OUT,
    output reg         CACHEABLE_OUT,
    output reg         PROT_VIOL_OUT,
    output reg         INIT_WRITE_OUT
);
    // ****************************************
    // reset release
    // ****************************************
    reg        rst_s1_r;
    reg        rst_s2_r;
    wire       rst_n;
    always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    // ****************************************
    // register file
    // ****************************************
    reg  [31:0] ctrl_r;
    reg  [31:0] entry_hi_r;
    reg  [31:0] entry_lo_r;
    reg  [31:0] table_base_r;
    reg  [31:0] fault_addr_r;
    reg  [31:0] rdata_nxt;
    reg         hit_reg;
    wire        wr_ok;
    wire        acc;
    wire        flush;

    // plain address decode, no buffer lookup on this path
    always @* begin
        hit_reg   = 1'b1;
        rdata_nxt = 32'h00000000;
        case (REG_ADDR_IN)
            `MMU_ADDR_CTRL:  rdata_nxt = ctrl_r;
            `MMU_ADDR_HIGH:  rdata_nxt = entry_hi_r;
            `MMU_ADDR_LOW:   rdata_nxt = entry_lo_r;
            `MMU_ADDR_TBASE: rdata_nxt = table_base_r;
            `MMU_ADDR_FAULT: rdata_nxt = fault_addr_r;
            default:         hit_reg = 1'b0;
        endcase
    end

    assign acc   = REG_WR_IN | REG_RD_IN;
    assign wr_ok = REG_WR_IN & PRIV_IN & hit_reg;
    assign flush = wr_ok & (REG_ADDR_IN == `MMU_ADDR_CTRL) & REG_WDATA_IN[`MMU_CTRL_TF];

    always @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r        <= `MMU_CTRL_RST;
            entry_hi_r    <= 32'h00000000;
            entry_lo_r    <= 32'h00000000;
            table_base_r  <= 32'h00000000;
            fault_addr_r  <= 32'h00000000;
            REG_RDATA_OUT <= 32'h00000000;
            REG_ACK_OUT   <= 1'b0;
            REG_ERR_OUT   <= 1'b0;
        end else begin
            REG_ACK_OUT   <= acc & PRIV_IN & hit_reg;
            REG_ERR_OUT   <= acc & ~(PRIV_IN & hit_reg);
            REG_RDATA_OUT <= (REG_RD_IN & PRIV_IN) ? rdata_nxt : 32'h00000000;
            if (wr_ok) begin
                case (REG_ADDR_IN)
                    // flush bit is a strobe and never stored
                    `MMU_ADDR_CTRL:  ctrl_r <= REG_WDATA_IN & `MMU_CTRL_MASK;
                    `MMU_ADDR_HIGH:  entry_hi_r <= REG_WDATA_IN;
                    `MMU_ADDR_LOW:   entry_lo_r <= REG_WDATA_IN;
                    `MMU_ADDR_TBASE: table_base_r <= REG_WDATA_IN;
                    `MMU_ADDR_FAULT: fault_addr_r <= REG_WDATA_IN;
                    default:         ctrl_r <= ctrl_r;
                endcase
            end
            // hardware capture wins over a same-cycle software write
            if (FAULT_IN) begin
                entry_hi_r[`MMU_HI_PAGE_MSB:`MMU_HI_PAGE_LSB] <=
                    FAULT_VADDR_IN[`MMU_HI_PAGE_MSB:`MMU_HI_PAGE_LSB];
                fault_addr_r <= FAULT_VADDR_IN;
            end
        end
    end

    // ****************************************
    // buffer storage
    // ****************************************
    // index is {way, set}
    reg  [14:0] vpn_hi_m [0:WAYS*SETS-1];
    reg  [1:0]  vpn_lo_m [0:WAYS*SETS-1];
    reg  [7:0]  process_space_id_m   [0:WAYS*SETS-1];
    reg  [18:0] ppn_m    [0:WAYS*SETS-1];
    reg  [5:0]  attr_m   [0:WAYS*SETS-1]; // share, size, key(2), cacheable, dirty
    reg  [WAYS*SETS-1:0] valid_r;
    reg  [1:0]  victim_r;
    wire [4:0]  load_set;
    wire [6:0]  load_idx;
    wire [7:0]  cur_process_space_id;

    assign cur_process_space_id = entry_hi_r[`MMU_HI_PROC_MSB:0];
    assign load_set = ctrl_r[`MMU_CTRL_XIDX] ?
                      (entry_hi_r[16:12] ^ cur_process_space_id[4:0]) : entry_hi_r[16:12];
    assign load_idx = {victim_r, load_set};

    // round-robin way choice; valid bits cleared by flush
    always @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            valid_r  <= {(WAYS*SETS){1'b0}};
            victim_r <= 2'h0;
        end else if (flush) begin
            valid_r <= {(WAYS*SETS){1'b0}};
        end else if (LOAD_ENTRY_IN) begin
            valid_r[load_idx] <= entry_lo_r[`MMU_LO_V];
            victim_r          <= victim_r + 2'h1;
        end
    end

    // array contents need no reset, validity guards them
    always @(posedge CORE_CLK_IN) begin
        if (LOAD_ENTRY_IN) begin
            vpn_hi_m[load_idx] <= entry_hi_r[31:17];
            vpn_lo_m[load_idx] <= entry_hi_r[11:10];
            process_space_id_m[load_idx]   <= cur_process_space_id;
            ppn_m[load_idx]    <= entry_lo_r[`MMU_LO_FRAME_MSB:`MMU_LO_FRAME_LSB];
            attr_m[load_idx]   <= {entry_lo_r[`MMU_LO_SHARE], entry_lo_r[`MMU_LO_SIZE],
                                   entry_lo_r[`MMU_LO_KEY_MSB:`MMU_LO_KEY_LSB],
                                   entry_lo_r[`MMU_LO_C], entry_lo_r[`MMU_LO_D]};
        end
    end

    // ****************************************
    // lookup
    // ****************************************
    wire [4:0]      lk_set;
    wire [WAYS-1:0] way_hit;
    wire            skip_process_space_id;

    assign lk_set    = ctrl_r[`MMU_CTRL_XIDX] ?
                       (LOOKUP_VADDR_IN[16:12] ^ cur_process_space_id[4:0]) : LOOKUP_VADDR_IN[16:12];
    assign skip_process_space_id = ctrl_r[`MMU_CTRL_SINGLE] & PRIV_IN;

    genvar w;
    generate
        for (w = 0; w < WAYS; w = w + 1) begin : g_way
            localparam [1:0] WAY_ID = w;
            wire [6:0] idx = {WAY_ID, lk_set};
            wire [5:0] at  = attr_m[idx];
            // bits 16-12 are implied by the set, 11-10 matter only for 1-kbyte pages
            assign way_hit[w] = valid_r[idx] &
                                (vpn_hi_m[idx] == LOOKUP_VADDR_IN[31:17]) &
                                (at[4] | (vpn_lo_m[idx] == LOOKUP_VADDR_IN[11:10])) &
                                (at[5] | skip_process_space_id | (process_space_id_m[idx] == cur_process_space_id));
        end
    endgenerate

    // software keeps hits unique, so a priority pick is enough
    reg [6:0] hit_idx;
    integer   k;
    always @* begin
        hit_idx = {2'h0, lk_set};
        for (k = WAYS - 1; k >= 0; k = k - 1) begin
            if (way_hit[k]) begin
                hit_idx = {k[1:0], lk_set};
            end
        end
    end

    wire [5:0]  h_attr = attr_m[hit_idx];
    wire [18:0] h_ppn  = ppn_m[hit_idx];
    wire        any_hit = |way_hit;
    wire        viol   = (~PRIV_IN & ~h_attr[3]) | (LOOKUP_WRITE_IN & ~h_attr[2]);
    wire [31:0] pa     = h_attr[4] ?
                         {1'b0, 2'h0, h_ppn[18:2], LOOKUP_VADDR_IN[11:0]} :
                         {1'b0, 2'h0, h_ppn, LOOKUP_VADDR_IN[9:0]};

    always @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            DONE_OUT       <= 1'b0;
            HIT_OUT        <= 1'b0;
            MISS_OUT       <= 1'b0;
            PADDR_OUT      <= 32'h00000000;
            CACHEABLE_OUT  <= 1'b0;
            PROT_VIOL_OUT  <= 1'b0;
            INIT_WRITE_OUT <= 1'b0;
        end else begin
            DONE_OUT       <= LOOKUP_IN;
            HIT_OUT        <= 1'b0;
            MISS_OUT       <= 1'b0;
            PROT_VIOL_OUT  <= 1'b0;
            INIT_WRITE_OUT <= 1'b0;
            if (LOOKUP_IN) begin
                if (!ctrl_r[`MMU_CTRL_AT]) begin
                    // translation off: address passes through, top three bits dropped
                    HIT_OUT       <= 1'b1;
                    PADDR_OUT     <= {3'h0, LOOKUP_VADDR_IN[28:0]};
                    CACHEABLE_OUT <= 1'b0;
                end else if (!any_hit) begin
                    MISS_OUT <= 1'b1;
                end else begin
                    HIT_OUT        <= 1'b1;
                    PADDR_OUT      <= pa;
                    CACHEABLE_OUT  <= h_attr[1];
                    PROT_VIOL_OUT  <= viol;
                    INIT_WRITE_OUT <= ~viol & LOOKUP_WRITE_IN & ~h_attr[0];
                end
            end
        end
    end
endmodule

// ---- verification/mmu_regs_tlb_checker.sv ----
// checker: timing relations at the translation unit ports
module mmu_chk (
    // watched ports
    input wire        CORE_CLK_IN,
    input wire        RSTN_IN,
    input wire        PRIV_IN,
    input wire        REG_WR_IN,
    input wire        REG_RD_IN,
    input wire        LOOKUP_IN,
    input wire        LOOKUP_WRITE_IN,
    input wire [31:0] LOOKUP_VADDR_IN,
    input wire [31:0] REG_RDATA_OUT,
    input wire        REG_ACK_OUT,
    input wire        REG_ERR_OUT,
    input wire        DONE_OUT,
    input wire        HIT_OUT,
    input wire        MISS_OUT,
    input wire [31:0] PADDR_OUT,
    input wire        PROT_VIOL_OUT,
    input wire        INIT_WRITE_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    wire req = REG_WR_IN | REG_RD_IN;
    AST_ANSWER: assert property (req |=> REG_ACK_OUT != REG_ERR_OUT)
        else $error("no single answer");
    AST_PRIV: assert property (req && !PRIV_IN |=> REG_ERR_OUT)
        else $error("user access taken");
    AST_ERR_DATA: assert property (REG_ERR_OUT |-> REG_RDATA_OUT == 32'h0)
        else $error("refused access gave data");
    AST_DONE: assert property (LOOKUP_IN |=> DONE_OUT && HIT_OUT != MISS_OUT)
        else $error("lookup not answered");
    AST_IDLE: assert property (!LOOKUP_IN |=> !DONE_OUT && !HIT_OUT && !MISS_OUT)
        else $error("answer without lookup");
    AST_OFFSET: assert property (HIT_OUT |-> PADDR_OUT[9:0] == $past(LOOKUP_VADDR_IN[9:0])
        && PADDR_OUT[31:29] == 3'h0)
        else $error("offset not passed");
    AST_INIT_WR: assert property (INIT_WRITE_OUT |-> HIT_OUT && !PROT_VIOL_OUT
        && $past(LOOKUP_WRITE_IN))
        else $error("bad initial write flag");
    AST_MISS: assert property (MISS_OUT |-> !PROT_VIOL_OUT && !INIT_WRITE_OUT)
        else $error("flags on a miss");
endmodule
bind mmu_regs_tlb mmu_chk i_mmu_chk (.CORE_CLK_IN, .RSTN_IN, .PRIV_IN, .REG_WR_IN,
    .REG_RD_IN, .LOOKUP_IN, .LOOKUP_WRITE_IN, .LOOKUP_VADDR_IN, .REG_RDATA_OUT,
    .REG_ACK_OUT, .REG_ERR_OUT, .DONE_OUT, .HIT_OUT, .MISS_OUT, .PADDR_OUT,
    .PROT_VIOL_OUT, .INIT_WRITE_OUT);

// ---- verification/mmu_core_model.sv ----
// core model: register accesses as one-cycle strobes
module mmu_core_model (
    input  wire         clk_in,
    input  wire  [31:0] rdata_in,
    input  wire         err_in,
    output logic        priv_out = 1'b1,
    output logic        wr_out = 1'b0,
    output logic        rd_out = 1'b0,
    output logic [31:0] addr_out = 32'h0,
    output logic [31:0] wdata_out = 32'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    // privilege is a level and stays as the last access left it
    task automatic acc(input logic p, w, input logic [31:0] a, d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_in);
        #1;
        priv_out = p;
        wr_out = w;
        rd_out = !w;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
        q = rdata_in;
        e = err_in;
    endtask
endmodule

// ---- verification/tb.sv ----
// testbench: register access, fault capture and buffer lookups
`include "mmu_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rstn = 1'b0, ld = 1'b0, flt = 1'b0, lk = 1'b0, lkw = 1'b0;
    logic        priv, wr, rd, ack, err, done, hit, miss, cach, pv, iw, e;
    logic [31:0] addr, wd, rdat, pa, q, p, fva = 32'h0, va = 32'h0;
    logic [31:0] ra [5] = '{`MMU_ADDR_CTRL, `MMU_ADDR_HIGH, `MMU_ADDR_LOW,
                            `MMU_ADDR_TBASE, `MMU_ADDR_FAULT};
    logic [31:0] rm [5] = '{32'h301, 32'hfffffcff, 32'h1ffffd7e, '1, '1};
    int          bad_count = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    mmu_regs_tlb i_mmu_regs_tlb (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .PRIV_IN(priv),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd),
        .REG_RDATA_OUT(rdat), .REG_ACK_OUT(ack), .REG_ERR_OUT(err), .LOAD_ENTRY_IN(ld),
        .FAULT_IN(flt), .FAULT_VADDR_IN(fva), .LOOKUP_IN(lk), .LOOKUP_WRITE_IN(lkw),
        .LOOKUP_VADDR_IN(va), .DONE_OUT(done), .HIT_OUT(hit), .MISS_OUT(miss),
        .PADDR_OUT(pa), .CACHEABLE_OUT(cach), .PROT_VIOL_OUT(pv), .INIT_WRITE_OUT(iw));
    mmu_core_model i_mmu_core_model (.clk_in(clk), .rdata_in(rdat), .err_in(err),
        .priv_out(priv), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wd));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [63:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rw(input logic pr, w, input logic [31:0] a, d);
        i_mmu_core_model.acc(pr, w, a, d, q, e);
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk);
        #1 s = 1'b1;
        @(posedge clk);
        #1 s = 1'b0;
    endtask
    task automatic look(input logic w, input logic [31:0] a);
        lkw = w;
        va = a;
        pulse(lk);
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #20us;
        bad_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_sim;
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 5; k++) begin
            p = 32'h9abcdef0 ^ k;
            rw(1, 0, ra[k], 0);
            chk({ack, e, q}, {2'b10, 32'h0});
            rw(1, 1, ra[k], p);
            rw(1, 0, ra[k], 0);
            chk(q & rm[k], p & rm[k]);
        end
        rw(1, 0, 32'h0fffffe4, 0);
        chk({ack, e, q}, {2'b01, 32'h0});
        rw(0, 1, ra[3], 32'h1);
        chk({ack, e}, 2'b01);
        rw(1, 0, ra[3], 0);
        chk(q, 32'h9abcdef3);
        $display("test registers done");
        rw(1, 1, ra[1], 32'h00000005);
        fva = 32'habcde7ff;
        pulse(flt);
        fva = 32'h0;
        rw(1, 0, ra[1], 0);
        chk(q & rm[1], 32'habcde405);
        rw(1, 1, ra[3], 32'h0);
        rw(1, 0, ra[4], 0);
        chk(q, 32'habcde7ff);
        rw(1, 0, ra[2], 0);
        chk(q & rm[2], 32'h9abcdef2 & rm[2]);
        $display("test fault done");
        rw(1, 1, ra[1], 32'h00403005);
        rw(1, 1, ra[2], 32'h0048d178);
        look(0, 32'he0403abc);
        chk({done, hit, miss, pa}, {3'b110, 32'h00403abc});
        rw(1, 1, ra[0], 32'h1);
        pulse(ld);
        look(0, 32'h00403abc);
        chk({done, hit, miss, cach, pv, iw, pa}, {6'b110100, 32'h0048dabc});
        look(1, 32'h00403abc);
        chk({hit, miss, pv, iw}, 4'b1001);
        look(0, 32'h00404abc);
        chk({hit, miss}, 2'b01);
        rw(1, 1, ra[1], 32'h00403006);
        look(0, 32'h00403abc);
        chk({hit, miss}, 2'b01);
        rw(1, 1, ra[0], 32'h101);
        look(0, 32'h00403abc);
        chk({hit, miss}, 2'b10);
        rw(0, 0, ra[3], 0);
        look(0, 32'h00403abc);
        chk({hit, miss}, 2'b01);
        rw(1, 1, ra[2], 32'h0048d11c);
        pulse(ld);
        rw(1, 1, ra[0], 32'h1);
        look(1, 32'h00403abc);
        chk({hit, miss, pv, iw}, 4'b1010);
        rw(1, 1, ra[0], 32'h5);
        look(0, 32'h00403abc);
        chk({hit, miss}, 2'b01);
        rw(1, 1, ra[0], 32'h201);
        rw(1, 1, ra[1], 32'h12345807);
        rw(1, 1, ra[2], 32'h02af3566);
        pulse(ld);
        look(0, 32'h12345abc);
        chk({hit, miss, cach, pv, iw, pa}, {5'b10000, 32'h02af36bc});
        look(0, 32'h123456bc);
        chk({hit, miss}, 2'b01);
        rw(1, 1, ra[1], 32'h12345806);
        look(0, 32'h12345abc);
        chk({hit, miss}, 2'b01);
        $display("test lookup done");
        end_sim;
    end
endmodule
